// *** design/ics_pkg.sv ***
// Package with the register map, field layout, reset values and timing for the inverter config/status bank.
package ics_pkg;

    // =====================================================================
    // Register addresses (16-bit register numbers on the serial bus)
    // =====================================================================
    localparam logic [15:0] ICS_ADDR_CHG_STAT = 16'h00B8;  // Charger stage status, read only.
    localparam logic [15:0] ICS_ADDR_SCALE0   = 16'h00C0;  // Scale codes byte 0 (high) and byte 1 (low).
    localparam logic [15:0] ICS_ADDR_SCALE1   = 16'h00C1;  // Scale codes byte 2 (high) and byte 3 (low).
    localparam logic [15:0] ICS_ADDR_SCALE2   = 16'h00C2;  // Scale codes byte 4 (high) and byte 5 (low).
    localparam logic [15:0] ICS_ADDR_SAVE_POL = 16'h00C4;  // Nonvolatile save policy.
    localparam logic [15:0] ICS_ADDR_OUT_CTRL = 16'h0100;  // Output and charger control.
    localparam logic [15:0] ICS_ADDR_PRIO     = 16'h0101;  // Operation priority select.

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int ICS_ST_FULL_BIT   = 0;   // Fully charged.
    localparam int ICS_ST_CC_BIT     = 1;   // Constant current stage.
    localparam int ICS_ST_CV_BIT     = 2;   // Constant voltage stage.
    localparam int ICS_ST_FLOAT_BIT  = 3;   // Float stage.
    localparam int ICS_ST_TSHORT_BIT = 10;  // Temperature sense short, high-byte bit 2.
    localparam int ICS_ST_CCTO_BIT   = 13;  // Constant current timeout, high-byte bit 5.
    localparam int ICS_ST_CVTO_BIT   = 14;  // Constant voltage timeout, high-byte bit 6.
    localparam int ICS_ST_FLTO_BIT   = 15;  // Float timeout, high-byte bit 7.
    localparam int ICS_SP_DLY_LSB    = 8;   // Save delay select, high-byte bits 1:0.
    localparam int ICS_SP_DIS_BIT    = 10;  // Save disable, high-byte bit 2.
    localparam int ICS_OC_ON_BIT     = 0;   // Output on command.
    localparam int ICS_OC_EN_BIT     = 1;   // Output command enable.
    localparam int ICS_OC_CHG_BIT    = 2;   // Bypass charger enable.

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic       ICS_RST_OUT_ON  = 1'b1;   // Output commanded on.
    localparam logic       ICS_RST_OUT_EN  = 1'b0;   // Remote output control disabled.
    localparam logic       ICS_RST_BYPASS_CHARGER_ENABLE  = 1'b1;   // Charger on in bypass.
    localparam logic       ICS_RST_SAVE_DIS = 1'b0;  // Saving enabled.
    localparam logic [1:0] ICS_RST_PRIO    = 2'h0;   // UPS mode.

    // =====================================================================
    // Encodings and timing
    // =====================================================================
    typedef enum logic [1:0] {ICS_DLY_NOW = 2'h0, ICS_DLY_1MIN = 2'h1, ICS_DLY_10MIN = 2'h2,
                              ICS_DLY_RSVD = 2'h3} ics_dly_t;
    localparam ics_dly_t ICS_RST_DLY = ICS_DLY_NOW;
    localparam logic [1:0] ICS_PRIO_UPS  = 2'h0;  // UPS mode.
    localparam logic [1:0] ICS_PRIO_SAVE = 2'h1;  // Energy-saving mode.
    localparam longint unsigned ICS_CLK_HZ      = 200_000_000;
    localparam longint unsigned ICS_SAVE_1MIN_S  = 60;
    localparam longint unsigned ICS_SAVE_10MIN_S = 600;
    localparam logic [39:0] ICS_SAVE_1MIN_CYC  = 40'(ICS_SAVE_1MIN_S * ICS_CLK_HZ);
    localparam logic [39:0] ICS_SAVE_10MIN_CYC = 40'(ICS_SAVE_10MIN_S * ICS_CLK_HZ);

    // Charger stage state and timeout indications from the charger controller.
    typedef struct packed {
        logic full;        // Fully charged.
        logic cc;          // Constant current stage active.
        logic cv;          // Constant voltage stage active.
        logic flt;         // Float stage active.
        logic temp_short;  // Temperature compensation sense shorted.
        logic cc_to;       // Constant current stage timed out.
        logic cv_to;       // Constant voltage stage timed out.
        logic flt_to;      // Float stage timed out.
    } ics_chg_stat_t;

    // Timeout report enables held in the charge curve configuration.
    typedef struct packed {
        logic cc;   // Constant current timeout report enable.
        logic cv;   // Constant voltage timeout report enable.
        logic flt;  // Float timeout report enable.
    } ics_to_en_t;

endpackage

// *** design/ics_regs.sv ***
// Inverter configuration and charger status register bank.
`timescale 1ns/100ps
module ics_regs import ics_pkg::*; #(
    parameter logic [3:0]  VOUT_CODE    = 4'h6,               // Output/DC voltage factor code.
    parameter logic [3:0]  IOUT_CODE    = 4'h6,               // Output/DC current factor code.
    parameter logic [3:0]  VIN_CODE     = 4'h6,               // Input/AC voltage factor code.
    parameter logic [3:0]  FAN_CODE     = 4'h7,               // Fan speed factor code.
    parameter logic [3:0]  TEMP_CODE    = 4'h6,               // Ambient temperature factor code.
    parameter logic [3:0]  TOUT_CODE    = 4'h7,               // Charge-stage timeout factor code.
    parameter logic [3:0]  IIN_CODE     = 4'h6,               // Input/AC current factor code.
    parameter logic [3:0]  WATT_CODE    = 4'h6,               // Output AC power factor code.
    parameter logic [3:0]  FREQ_CODE    = 4'h5,               // Frequency factor code.
    parameter logic [39:0] SAVE_1MIN_CYC  = ICS_SAVE_1MIN_CYC,  // Cycles in one minute.
    parameter logic [39:0] SAVE_10MIN_CYC = ICS_SAVE_10MIN_CYC  // Cycles in ten minutes.
) (
    // Clock and reset.
    input  wire logic          CLK_SYS_I,
    input  wire logic          SYS_RST_I,
    // Register access port.
    input  wire logic [15:0]   REG_ADDR_I,
    input  wire logic          REG_WR_I,
    input  wire logic [15:0]   REG_WDATA_I,
    input  wire logic          REG_RD_I,
    output logic      [15:0]   REG_RDATA_O,
    output logic               REG_ACK_O,
    output logic               REG_ERR_O,
    // Charger controller side.
    input  wire ics_chg_stat_t CHG_STAT_I,
    input  wire ics_to_en_t    TO_REPORT_EN_I,
    // Nonvolatile storage side.
    input  wire logic          PARAM_CHANGED_I,
    output logic               SAVE_COMMIT_O,
    // Inverter control outputs.
    output logic               OUT_CMD_ACTIVE_O,
    output logic               OUT_ON_REQ_O,
    output logic               BYP_BYPASS_CHARGER_ENABLE_O,
    output logic      [1:0]    OP_PRIO_O
);

    // =====================================================================
    // Decode helpers
    // =====================================================================
    // True for any address this bank answers.
    function automatic logic is_mapped(input logic [15:0] a);
        is_mapped = (a == ICS_ADDR_CHG_STAT) || (a == ICS_ADDR_SCALE0) || (a == ICS_ADDR_SCALE1) ||
                    (a == ICS_ADDR_SCALE2) || (a == ICS_ADDR_SAVE_POL) || (a == ICS_ADDR_OUT_CTRL) ||
                    (a == ICS_ADDR_PRIO);
    endfunction

    // True for the writable registers only.
    function automatic logic is_writable(input logic [15:0] a);
        is_writable = (a == ICS_ADDR_SAVE_POL) || (a == ICS_ADDR_OUT_CTRL) || (a == ICS_ADDR_PRIO);
    endfunction

    // Reserved and unsupported factor codes read as zero.
    function automatic logic [3:0] legal_code(input logic [3:0] c);
        legal_code = (c >= 4'h4 && c <= 4'h9) ? c : 4'h0;
    endfunction

    // =====================================================================
    // State
    // =====================================================================
    logic [15:0] stat_r;             // Snapshot of charger status word.
    logic        out_on_r;           // Output on command.
    logic        out_en_r;           // Output command enable.
    logic        bypass_charger_enable_r;           // Bypass charger enable.
    logic [1:0]  prio_r;             // Operation priority.
    ics_dly_t    save_dly_r;         // Save delay select.
    logic        save_dis_r;         // Save disable.
    logic [39:0] idle_cnt_r;         // Cycles with no parameter change.
    logic        commit_r;           // Commit pulse register.
    logic        wr_ok;              // Accepted write to a writable register.
    logic        change_evt;         // A parameter changed this cycle.
    logic [39:0] save_limit;         // Wait length for the current policy.
    logic [47:0] scale_w;            // Six scale bytes, byte 0 in the top.

    typedef enum {SV_IDLE, SV_WAIT} ics_save_st_t;
    ics_save_st_t save_st_r;         // Save scheduler state.

    // Scale table; the unused upper nibble of byte 4 and all of byte 5 are zero.
    assign scale_w = {legal_code(IOUT_CODE), legal_code(VOUT_CODE),
                      legal_code(FAN_CODE),  legal_code(VIN_CODE),
                      legal_code(TOUT_CODE), legal_code(TEMP_CODE),
                      legal_code(WATT_CODE), legal_code(IIN_CODE),
                      4'h0, legal_code(FREQ_CODE), 8'h00};

    // Only writes to writable registers count; read-only targets are refused.
    assign wr_ok = REG_WR_I && is_writable(REG_ADDR_I);

    // Writes to the control registers, and external setting changes, count as changes.
    assign change_evt = PARAM_CHANGED_I ||
                        (wr_ok && (REG_ADDR_I == ICS_ADDR_OUT_CTRL || REG_ADDR_I == ICS_ADDR_PRIO));

    // The wait length follows the policy in force now, so a policy change takes effect at once.
    assign save_limit = (save_dly_r == ICS_DLY_10MIN) ? SAVE_10MIN_CYC : SAVE_1MIN_CYC;

    // =====================================================================
    // Charger status capture
    // =====================================================================
    // Sampled every cycle; timeout flags appear only when their report is enabled.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            stat_r <= 16'h0000;
        end else begin
            stat_r                    <= 16'h0000;
            stat_r[ICS_ST_FULL_BIT]   <= CHG_STAT_I.full;
            stat_r[ICS_ST_CC_BIT]     <= CHG_STAT_I.cc;
            stat_r[ICS_ST_CV_BIT]     <= CHG_STAT_I.cv;
            stat_r[ICS_ST_FLOAT_BIT]  <= CHG_STAT_I.flt;
            stat_r[ICS_ST_TSHORT_BIT] <= CHG_STAT_I.temp_short;
            stat_r[ICS_ST_CCTO_BIT]   <= CHG_STAT_I.cc_to && TO_REPORT_EN_I.cc;
            stat_r[ICS_ST_CVTO_BIT]   <= CHG_STAT_I.cv_to && TO_REPORT_EN_I.cv;
            stat_r[ICS_ST_FLTO_BIT]   <= CHG_STAT_I.flt_to && TO_REPORT_EN_I.flt;
        end
    end

    // =====================================================================
    // Writable registers
    // =====================================================================
    // Output and charger control; reserved bits are simply not stored.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            out_on_r <= ICS_RST_OUT_ON;
            out_en_r <= ICS_RST_OUT_EN;
            bypass_charger_enable_r <= ICS_RST_BYPASS_CHARGER_ENABLE;
        end else if (wr_ok && REG_ADDR_I == ICS_ADDR_OUT_CTRL) begin
            out_on_r <= REG_WDATA_I[ICS_OC_ON_BIT];
            out_en_r <= REG_WDATA_I[ICS_OC_EN_BIT];
            bypass_charger_enable_r <= REG_WDATA_I[ICS_OC_CHG_BIT];
        end
    end

    // Priority; reserved codes leave the stored mode unchanged.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            prio_r <= ICS_RST_PRIO;
        end else if (wr_ok && REG_ADDR_I == ICS_ADDR_PRIO &&
                     (REG_WDATA_I[1:0] == ICS_PRIO_UPS || REG_WDATA_I[1:0] == ICS_PRIO_SAVE)) begin
            prio_r <= REG_WDATA_I[1:0];
        end
    end

    // Save policy; the reserved delay code keeps the old delay, the disable bit is still taken.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            save_dly_r <= ICS_RST_DLY;
            save_dis_r <= ICS_RST_SAVE_DIS;
        end else if (wr_ok && REG_ADDR_I == ICS_ADDR_SAVE_POL) begin
            save_dis_r <= REG_WDATA_I[ICS_SP_DIS_BIT];
            if (REG_WDATA_I[ICS_SP_DLY_LSB +: 2] != ICS_DLY_RSVD) begin
                save_dly_r <= ics_dly_t'(REG_WDATA_I[ICS_SP_DLY_LSB +: 2]);
            end
        end
    end

    // =====================================================================
    // Nonvolatile save scheduler
    // =====================================================================
    // A pending save waits for a quiet interval; each new change restarts it. Disabling
    // saving drops whatever was pending, so nothing stale is written when it is re-enabled.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            save_st_r  <= SV_IDLE;
            idle_cnt_r <= 40'h00_0000_0000;
            commit_r   <= 1'b0;
        end else begin
            commit_r <= 1'b0;
            unique case (save_st_r)
                SV_IDLE: begin
                    idle_cnt_r <= 40'h00_0000_0000;
                    if (change_evt && !save_dis_r) begin
                        if (save_dly_r == ICS_DLY_NOW) begin
                            commit_r <= 1'b1;
                        end else begin
                            save_st_r <= SV_WAIT;
                        end
                    end
                end
                SV_WAIT: begin
                    if (save_dis_r) begin
                        save_st_r  <= SV_IDLE;
                    end else if (change_evt) begin
                        idle_cnt_r <= 40'h00_0000_0000;
                    end else if (save_dly_r == ICS_DLY_NOW || idle_cnt_r >= save_limit - 40'h00_0000_0001) begin
                        commit_r   <= 1'b1;
                        save_st_r  <= SV_IDLE;
                    end else begin
                        idle_cnt_r <= idle_cnt_r + 40'h00_0000_0001;
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // Register access answer
    // =====================================================================
    // Every access is answered one cycle later by ACK or by ERR, never both.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O <= 16'h0000;
            REG_ACK_O   <= 1'b0;
            REG_ERR_O   <= 1'b0;
        end else begin
            REG_ACK_O <= 1'b0;
            REG_ERR_O <= 1'b0;
            if (REG_RD_I) begin
                REG_ACK_O <= is_mapped(REG_ADDR_I);
                REG_ERR_O <= !is_mapped(REG_ADDR_I);
                unique case (REG_ADDR_I)
                    ICS_ADDR_CHG_STAT: REG_RDATA_O <= stat_r;
                    ICS_ADDR_SCALE0:   REG_RDATA_O <= scale_w[47:32];
                    ICS_ADDR_SCALE1:   REG_RDATA_O <= scale_w[31:16];
                    ICS_ADDR_SCALE2:   REG_RDATA_O <= scale_w[15:0];
                    ICS_ADDR_SAVE_POL: REG_RDATA_O <= {5'h00, save_dis_r, save_dly_r, 8'h00};
                    ICS_ADDR_OUT_CTRL: REG_RDATA_O <= {13'h0000, bypass_charger_enable_r, out_en_r, out_on_r};
                    ICS_ADDR_PRIO:     REG_RDATA_O <= {14'h0000, prio_r};
                    default:           REG_RDATA_O <= 16'h0000;
                endcase
            end else if (REG_WR_I) begin
                REG_ACK_O <= wr_ok;
                REG_ERR_O <= !wr_ok;
            end
        end
    end

    // =====================================================================
    // Outputs to the inverter and the nonvolatile store
    // =====================================================================
    // The on/off bit only steers the output while the enable is set; otherwise the
    // output follows local control and the on request is held at its reset value, on.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            OUT_CMD_ACTIVE_O <= ICS_RST_OUT_EN;
            OUT_ON_REQ_O     <= ICS_RST_OUT_ON;
            BYP_BYPASS_CHARGER_ENABLE_O     <= ICS_RST_BYPASS_CHARGER_ENABLE;
            OP_PRIO_O        <= ICS_RST_PRIO;
            SAVE_COMMIT_O    <= 1'b0;
        end else begin
            OUT_CMD_ACTIVE_O <= out_en_r;
            OUT_ON_REQ_O     <= out_en_r ? out_on_r : ICS_RST_OUT_ON;
            BYP_BYPASS_CHARGER_ENABLE_O     <= bypass_charger_enable_r;
            OP_PRIO_O        <= prio_r;
            SAVE_COMMIT_O    <= commit_r;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_change_now;
        change_evt && !save_dis_r && save_dly_r == ICS_DLY_NOW && save_st_r == SV_IDLE;
    endsequence

    // The internal pulse comes one edge after the change, the output pulse one edge after that.
    sequence s_commit_soon;
        ##1 commit_r ##1 SAVE_COMMIT_O;
    endsequence

    a_stage_flags: assert property (##1 stat_r[3:0] ==
        {$past(CHG_STAT_I.flt), $past(CHG_STAT_I.cv), $past(CHG_STAT_I.cc), $past(CHG_STAT_I.full)})
        else $error("charge stage flags do not follow the charger");
    a_temp_short: assert property (##1 stat_r[ICS_ST_TSHORT_BIT] == $past(CHG_STAT_I.temp_short))
        else $error("temperature short flag wrong");
    a_timeout_gate: assert property (CHG_STAT_I.cc_to && !TO_REPORT_EN_I.cc |=>
        !stat_r[ICS_ST_CCTO_BIT]) else $error("timeout shown while report disabled");
    a_timeout_show: assert property (CHG_STAT_I.flt_to && TO_REPORT_EN_I.flt |=>
        stat_r[ICS_ST_FLTO_BIT]) else $error("float timeout not shown");
    a_status_rsvd: assert property ({stat_r[12:11], stat_r[9:4]} == 8'h00)
        else $error("reserved status bit set");
    a_scale_top: assert property (REG_RD_I && REG_ADDR_I == ICS_ADDR_SCALE2 |=>
        REG_ACK_O && REG_RDATA_O[15:12] == 4'h0 && REG_RDATA_O[7:0] == 8'h00)
        else $error("reserved scale bytes not zero");
    a_ro_refused: assert property (REG_WR_I && !REG_RD_I && REG_ADDR_I == ICS_ADDR_CHG_STAT |=>
        REG_ERR_O && !REG_ACK_O) else $error("write to read-only register not refused");
    a_out_gate: assert property (##1 OUT_ON_REQ_O == ($past(out_en_r) ? $past(out_on_r) : 1'b1))
        else $error("output request not gated by enable");
    a_save_now: assert property (s_change_now |-> s_commit_soon)
        else $error("immediate save did not commit");
    a_save_off: assert property (save_dis_r |-> ##1 !commit_r)
        else $error("save committed while disabled");
    a_prio_legal: assert property (!prio_r[1])
        else $error("reserved priority code stored");
    a_restart: assert property (save_st_r == SV_WAIT && change_evt && !save_dis_r |=>
        idle_cnt_r == 40'h00_0000_0000 && !commit_r) else $error("quiet counter not restarted");

endmodule // ics_regs

// *** test/ics_far_model.sv ***
// Behavioural model of the charger controller and nonvolatile store beside the bank.
`timescale 1ns/100ps
module ics_far_model import ics_pkg::*; (
    // Clock.
    input  wire logic          clk_i,
    // Charger state and change requests wanted by the bench.
    input  wire ics_chg_stat_t want_i,
    input  wire ics_to_en_t    want_en_i,
    input  wire logic          bump_i,
    // Bank side.
    input  wire logic          commit_i,
    output ics_chg_stat_t      stat_o,
    output ics_to_en_t         to_en_o,
    output logic               changed_o,
    output int                 commits_o
);
    // The bench already drives on the falling edge, so the charger levels pass straight through.
    assign stat_o    = want_i;
    assign to_en_o   = want_en_i;
    assign changed_o = bump_i;
    // Every commit pulse stands for one store write.
    initial commits_o = 0;
    always @(posedge clk_i) if (commit_i === 1'b1) commits_o <= commits_o + 1;
endmodule // ics_far_model

// *** test/tb_top.sv ***
// Self-checking bench for the config and status register bank.
`timescale 1ns/100ps
module tb_top import ics_pkg::*;;
    logic          clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bump = 1'b0;
    logic [15:0]   addr = 16'h0, wd = 16'h0;
    ics_chg_stat_t want = 8'h0;
    ics_to_en_t    ten_w = 3'h0;
    wire ics_chg_stat_t stat;
    wire ics_to_en_t    ten;
    wire [15:0]    rdat;
    wire           ack, err, commit, act, onr, byp, chg;
    wire [1:0]     prio;
    int            commits, errors = 0, compares = 0;
    wire [15:0]    outs = {11'h0, act, onr, byp, prio};
    always #2.5 clk = ~clk;
    // Odd scale codes (0x3, 0xA) must read back as zero; 0x4 is the lowest legal code; others keep defaults.
    ics_regs #(.VOUT_CODE(4'h4), .FAN_CODE(4'hA), .WATT_CODE(4'h3),
        .SAVE_1MIN_CYC(40'h14), .SAVE_10MIN_CYC(40'h32)) DUT (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wd),
        .REG_RD_I(rd), .REG_RDATA_O(rdat), .REG_ACK_O(ack), .REG_ERR_O(err), .CHG_STAT_I(stat),
        .TO_REPORT_EN_I(ten), .PARAM_CHANGED_I(chg), .SAVE_COMMIT_O(commit), .OUT_CMD_ACTIVE_O(act),
        .OUT_ON_REQ_O(onr), .BYP_BYPASS_CHARGER_ENABLE_O(byp), .OP_PRIO_O(prio));
    ics_far_model far (.clk_i(clk), .want_i(want), .want_en_i(ten_w), .bump_i(bump), .commit_i(commit),
        .stat_o(stat), .to_en_o(ten), .changed_o(chg), .commits_o(commits));
    task automatic end_of_test;
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access: request for one cycle, answer is looked at in the cycle it stands.
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(negedge clk);
        wr = w; rd = !w; addr = a; wd = d;
        @(negedge clk);
        wr = 1'b0; rd = 1'b0;
        chk({14'h0, ack, err}, (w && exp[0]) ? 16'h1 : 16'h2);
        if (!w) chk(rdat, exp);
    endtask
    // Control outputs follow a write one cycle after its answer.
    task automatic ochk(input logic [15:0] exp);
        @(negedge clk);
        chk(outs, exp);
    endtask
    task automatic bumpit;
        @(negedge clk) bump = 1'b1;
        @(negedge clk) bump = 1'b0;
    endtask
    // A commit must land inside lo..hi cycles, or not at all when none is wanted.
    task automatic save_chk(input int lo, input int hi, input logic want_c);
        int c0;
        int n;
        c0 = commits;
        for (n = 0; n < hi && commits == c0; n++) @(negedge clk);
        chk({15'h0, commits != c0}, {15'h0, want_c});
        if (want_c && n < lo) chk(16'(n), 16'(lo));
        if (want_c && commits == c0) end_of_test();
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(outs, 16'h000C);
        acc(1'b0, ICS_ADDR_OUT_CTRL, 16'h0, 16'h0005);
        acc(1'b0, ICS_ADDR_PRIO, 16'h0, 16'h0000);
        acc(1'b0, ICS_ADDR_SAVE_POL, 16'h0, 16'h0000);
        acc(1'b0, ICS_ADDR_SCALE0, 16'h0, 16'h6406);
        acc(1'b0, ICS_ADDR_SCALE1, 16'h0, 16'h7606);
        acc(1'b0, ICS_ADDR_SCALE2, 16'h0, 16'h0500);
        acc(1'b1, ICS_ADDR_CHG_STAT, 16'hFFFF, 16'h1);
        acc(1'b1, ICS_ADDR_SCALE0, 16'hFFFF, 16'h1);
        acc(1'b1, 16'h0050, 16'h0001, 16'h1);
        want = 8'hFF;
        acc(1'b0, ICS_ADDR_CHG_STAT, 16'h0, 16'h040F);
        want = 8'hA5; ten_w = 3'h6;
        acc(1'b0, ICS_ADDR_CHG_STAT, 16'h0, 16'h2005);
        ten_w = 3'h7;
        acc(1'b0, ICS_ADDR_CHG_STAT, 16'h0, 16'hA005);
        acc(1'b1, ICS_ADDR_OUT_CTRL, 16'hFFF8, 16'h0);
        acc(1'b0, ICS_ADDR_OUT_CTRL, 16'h0, 16'h0000);
        ochk(16'h0008);
        acc(1'b1, ICS_ADDR_OUT_CTRL, 16'h0003, 16'h0);
        ochk(16'h0018);
        acc(1'b1, ICS_ADDR_OUT_CTRL, 16'h0002, 16'h0);
        ochk(16'h0010);
        acc(1'b1, ICS_ADDR_PRIO, 16'h0001, 16'h0);
        ochk(16'h0011);
        acc(1'b1, ICS_ADDR_PRIO, 16'h0002, 16'h0);
        acc(1'b0, ICS_ADDR_PRIO, 16'h0, 16'h0001);
        bumpit();
        save_chk(1, 8, 1'b1);
        acc(1'b1, ICS_ADDR_SAVE_POL, 16'h0100, 16'h0);
        bumpit();
        repeat (10) @(negedge clk);
        bumpit();
        save_chk(15, 35, 1'b1);
        acc(1'b1, ICS_ADDR_SAVE_POL, 16'h0200, 16'h0);
        bumpit();
        save_chk(45, 65, 1'b1);
        acc(1'b1, ICS_ADDR_SAVE_POL, 16'h0400, 16'h0);
        acc(1'b0, ICS_ADDR_SAVE_POL, 16'h0, 16'h0400);
        // Reserved delay code: the old delay stays, the disable bit is still taken.
        acc(1'b1, ICS_ADDR_SAVE_POL, 16'hFF03, 16'h0);
        acc(1'b0, ICS_ADDR_SAVE_POL, 16'h0, 16'h0400);
        bumpit();
        save_chk(0, 80, 1'b0);
        end_of_test();
    end
endmodule // tb_top
